// [hdl/async_start_stop_serial_framer.sv]
// start-stop serial transmitter and receiver with 16x oversampling
// assumes line and control inputs are synchronous to core_clk and that
// the far end uses the same character length, parity and stop setting
`timescale 1ns/1ps
// How it works
// - every sent character begins with one low start element of one bit time.
// - after the last bit the transmitter drives a high stop element.
// - between characters the line stays high for as long as no data waits.
// - the character length is chosen as five to eight data bits for both ends.
// - the stop element is one or two bit times, or one and a half for five bits.
// - the receiver restarts its tick counter on the falling edge of the start.
// - the receiver counts 16x ticks from that edge to find each bit centre.
// - sampling on the eighth tick keeps every sample within 1/16 bit of centre.
// - the receiver looks for a new start right after the stop centre sample.
// - a character interval shortened by up to half a bit is still received.
// - a waiting character is sent at the next tick, with no clock on the line.
// - received characters are presented in parallel with framing bits removed.
// - parity mismatch, missing stop and overrun are flagged per character.
// - the transmit bit time is sixteen ticks of the 16x enable.
module async_start_stop_serial_framer #(
  parameter int DATA_WIDTH = framer_pkg::MAX_BITS,
  parameter int DEPTH = framer_pkg::FIFO_DEPTH,
  parameter int DIV_WIDTH = framer_pkg::DIV_WIDTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [DIV_WIDTH-1:0] tick_div,
  input wire logic [1:0] word_len,
  input wire logic parity_en,
  input wire logic parity_even,
  input wire logic two_stop,
  input wire logic [DATA_WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_line,
  input wire logic rx_line,
  output logic [DATA_WIDTH-1:0] rx_data,
  output logic rx_avail,
  input wire logic rx_unload,
  output logic parity_err,
  output logic frame_err,
  output logic overrun_err
);
  stream_if #(.WIDTH(DATA_WIDTH)) in_s ();
  stream_if #(.WIDTH(DATA_WIDTH)) out_s ();
  logic tick;
  logic [2:0] last_bit;
  logic [DATA_WIDTH-1:0] len_mask;
  framer_pkg::tx_state_e tx_state_reg;
  logic [3:0] tx_cnt_reg;
  logic [5:0] tx_stop_cnt_reg;
  logic [2:0] tx_idx_reg;
  logic [DATA_WIDTH-1:0] tx_shift_reg;
  logic tx_par_reg;
  logic [5:0] stop_ticks;
  logic tx_take;
  framer_pkg::rx_state_e rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_idx_reg;
  logic [DATA_WIDTH-1:0] rx_shift_reg;
  logic rx_prev_reg;
  logic rx_sample;
  logic rx_edge;
  logic rx_done;
  logic rx_done_frame;

  // parity of the bits that belong to the character
  function automatic logic par_of(input logic [DATA_WIDTH-1:0] d,
                                  input logic [DATA_WIDTH-1:0] m, input logic even);
    par_of = (^(d & m)) ^ ~even;
  endfunction

  tick_divider #(.WIDTH(DIV_WIDTH)) u_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .div_value(tick_div),
    .tick(tick)
  );

  word_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_s(in_s.snk),
    .out_s(out_s.src)
  );

  // user side of the transmit buffer
  assign in_s.valid = tx_valid;
  assign in_s.data = tx_data;
  assign tx_ready = in_s.ready;

  assign last_bit = framer_pkg::MIN_BITS_M1 + {1'b0, word_len};
  // widen the shift count so an eight-bit length does not wrap to zero
  assign len_mask = DATA_WIDTH'(({DATA_WIDTH{1'b1}} << ({1'b0, last_bit} + 4'h1)) ^
                                {DATA_WIDTH{1'b1}});

  always_comb begin
    if (!two_stop) begin
      stop_ticks = framer_pkg::STOP_ONE;
    end else if (word_len == framer_pkg::LEN_5) begin
      stop_ticks = framer_pkg::STOP_ONE_HALF;
    end else begin
      stop_ticks = framer_pkg::STOP_TWO;
    end
  end

  // take a waiting character on a tick
  assign tx_take = (tx_state_reg == framer_pkg::TX_IDLE) && tick && out_s.valid;
  assign out_s.ready = tx_take;

  // transmit sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= framer_pkg::TX_IDLE;
      tx_cnt_reg <= '0;
      tx_stop_cnt_reg <= '0;
      tx_idx_reg <= '0;
      tx_shift_reg <= framer_pkg::DATA_RESET;
      tx_par_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        framer_pkg::TX_IDLE: begin
          if (tx_take) begin
            tx_state_reg <= framer_pkg::TX_START;
            tx_shift_reg <= out_s.data;
            tx_par_reg <= par_of(out_s.data, len_mask, parity_even);
            tx_cnt_reg <= '0;
          end
        end
        framer_pkg::TX_START: begin
          if (tick) begin
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
            if (tx_cnt_reg == framer_pkg::TICK_LAST) begin
              tx_state_reg <= framer_pkg::TX_DATA;
              tx_idx_reg <= '0;
            end
          end
        end
        framer_pkg::TX_DATA: begin
          if (tick) begin
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
            if (tx_cnt_reg == framer_pkg::TICK_LAST) begin
              tx_shift_reg <= tx_shift_reg >> 1;
              tx_idx_reg <= tx_idx_reg + 1'b1;
              if (tx_idx_reg == last_bit) begin
                tx_state_reg <= parity_en ? framer_pkg::TX_PARITY : framer_pkg::TX_STOP;
                tx_stop_cnt_reg <= '0;
              end
            end
          end
        end
        framer_pkg::TX_PARITY: begin
          if (tick) begin
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
            if (tx_cnt_reg == framer_pkg::TICK_LAST) begin
              tx_state_reg <= framer_pkg::TX_STOP;
              tx_stop_cnt_reg <= '0;
            end
          end
        end
        framer_pkg::TX_STOP: begin
          // stop lasts its chosen tick count
          if (tick) begin
            tx_stop_cnt_reg <= tx_stop_cnt_reg + 1'b1;
            if (tx_stop_cnt_reg >= stop_ticks) begin
              tx_state_reg <= framer_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= framer_pkg::TX_IDLE;
      endcase
    end
  end

  // line driver, one flop for all levels
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_line <= framer_pkg::LINE_MARK;
    end else begin
      case (tx_state_reg)
        framer_pkg::TX_START: tx_line <= 1'b0;
        framer_pkg::TX_DATA: tx_line <= tx_shift_reg[0];
        framer_pkg::TX_PARITY: tx_line <= tx_par_reg;
        framer_pkg::TX_STOP: tx_line <= framer_pkg::LINE_MARK;
        default: tx_line <= framer_pkg::LINE_MARK;
      endcase
    end
  end

  // falling edge seen at tick rate
  assign rx_edge = tick && rx_prev_reg && !rx_line;
  assign rx_sample = tick && (rx_cnt_reg == framer_pkg::SAMPLE_PHASE);
  assign rx_done = rx_sample && (rx_state_reg == framer_pkg::RX_STOP);
  assign rx_done_frame = rx_done && !rx_line;

  // receive sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= framer_pkg::RX_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= '0;
      rx_shift_reg <= framer_pkg::DATA_RESET;
      rx_prev_reg <= framer_pkg::LINE_MARK;
    end else begin
      if (tick) begin
        rx_prev_reg <= rx_line;
      end
      // free running tick count after the edge
      if (tick) begin
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
      end
      case (rx_state_reg)
        framer_pkg::RX_IDLE: begin
          if (rx_edge) begin
            rx_state_reg <= framer_pkg::RX_START;
            rx_cnt_reg <= '0;
            rx_shift_reg <= '0;
          end
        end
        framer_pkg::RX_START: begin
          if (rx_sample) begin
            rx_state_reg <= rx_line ? framer_pkg::RX_IDLE : framer_pkg::RX_DATA;
            rx_idx_reg <= '0;
          end
        end
        framer_pkg::RX_DATA: begin
          // first data bit lands in bit zero
          if (rx_sample) begin
            rx_shift_reg[rx_idx_reg] <= rx_line;
            rx_idx_reg <= rx_idx_reg + 1'b1;
            if (rx_idx_reg == last_bit) begin
              rx_state_reg <= parity_en ? framer_pkg::RX_PARITY : framer_pkg::RX_STOP;
            end
          end
        end
        framer_pkg::RX_PARITY: begin
          if (rx_sample) begin
            rx_state_reg <= framer_pkg::RX_STOP;
          end
        end
        framer_pkg::RX_STOP: begin
          // leaves half a bit for an early start
          if (rx_sample) begin
            rx_state_reg <= framer_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= framer_pkg::RX_IDLE;
      endcase
    end
  end

  // parity check register, taken at the parity centre
  logic rx_par_bad_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_par_bad_reg <= 1'b0;
    end else if (rx_edge && rx_state_reg == framer_pkg::RX_IDLE) begin
      rx_par_bad_reg <= 1'b0;
    end else if (rx_sample && rx_state_reg == framer_pkg::RX_PARITY) begin
      rx_par_bad_reg <= rx_line != par_of(rx_shift_reg, len_mask, parity_even);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data <= framer_pkg::DATA_RESET;
      rx_avail <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data <= rx_shift_reg & len_mask;
      end
      // new character wins over an unload in the same cycle
      if (rx_done) begin
        rx_avail <= 1'b1;
      end else if (rx_unload) begin
        rx_avail <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      parity_err <= 1'b0;
      frame_err <= 1'b0;
      overrun_err <= 1'b0;
    end else if (rx_done) begin
      parity_err <= parity_en && rx_par_bad_reg;
      frame_err <= rx_done_frame;
      overrun_err <= rx_avail && !rx_unload;
    end
  end

  // ticks counted from the start edge, kept for the checks only
  logic [7:0] rx_ticks_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_ticks_reg <= '0;
    end else if (rx_edge && rx_state_reg == framer_pkg::RX_IDLE) begin
      rx_ticks_reg <= '0;
    end else if (tick) begin
      rx_ticks_reg <= rx_ticks_reg + 1'b1;
    end
  end

  // checks
  idle_mark_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_IDLE) && tx_state_reg == framer_pkg::TX_IDLE
    |-> tx_line) else $error("line not at mark while idle");
  start_space_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_START) && tx_state_reg == framer_pkg::TX_START
    |-> !tx_line) else $error("start element not at space");
  start_length_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_START) && tx_state_reg == framer_pkg::TX_DATA
    |-> $past(tx_cnt_reg) == 4'hf && $past(tick)) else $error("start not sixteen ticks");
  stop_mark_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_STOP) |-> tx_line) else $error("stop not at mark");
  word_bits_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_DATA) && tx_state_reg != framer_pkg::TX_DATA
    |-> $past(tx_idx_reg) == $past(last_bit)) else $error("wrong data bit count");
  stop_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(tx_state_reg == framer_pkg::TX_STOP) && tx_state_reg == framer_pkg::TX_IDLE
    |-> $past(tx_stop_cnt_reg) == $past(stop_ticks)) else $error("stop length wrong");
  send_prompt_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tx_take |=> tx_state_reg == framer_pkg::TX_START ##1 !tx_line)
    else $error("waiting character not started");
  edge_restart_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_edge && rx_state_reg == framer_pkg::RX_IDLE
    |=> rx_cnt_reg == 4'h0 && rx_state_reg == framer_pkg::RX_START)
    else $error("counter not restarted on start edge");
  sample_phase_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_sample && rx_state_reg == framer_pkg::RX_DATA
    |-> rx_ticks_reg == {1'b0, rx_idx_reg, 4'h7} + 8'h10) else $error("sample off centre");
  rearm_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_done |=> rx_state_reg == framer_pkg::RX_IDLE) else $error("receiver not rearmed");
  present_char_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_done |=> rx_avail && rx_data == ($past(rx_shift_reg) & $past(len_mask)))
    else $error("character not presented");
  overrun_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_done && rx_avail && !rx_unload |=> overrun_err) else $error("overrun not flagged");
  char_sent_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    tx_state_reg == framer_pkg::TX_STOP ##1 tx_state_reg == framer_pkg::TX_IDLE);
  char_recv_c: cover property (@(posedge core_clk) disable iff (!reset_n) rx_done);
  overrun_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    rx_done && rx_avail);
  fifo_full_c: cover property (@(posedge core_clk) disable iff (!reset_n) !tx_ready);
endmodule

// [hdl/framer_pkg.sv]
// constants shared by the start-stop serial framer and its helpers
// assumes a single core clock; all serial timing is in 16x ticks
package framer_pkg;
  // core clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_RATE_HZ = 1000000000 / CLK_PERIOD_NS;
  // oversampling
  localparam int TICKS_PER_BIT = 16;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  // stop element lengths in ticks, each less one
  localparam logic [5:0] STOP_ONE = 6'h0f;
  localparam logic [5:0] STOP_ONE_HALF = 6'h17;
  localparam logic [5:0] STOP_TWO = 6'h1f;
  // character length
  localparam int MIN_BITS = 5;
  localparam int MAX_BITS = 8;
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [2:0] MIN_BITS_M1 = 3'h4;
  // fifo and divider defaults
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_WIDTH = 16;
  // reset values
  localparam logic LINE_MARK = 1'b1;
  localparam logic [MAX_BITS-1:0] DATA_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
endpackage

// [hdl/stream_if.sv]
// valid/ready word stream between the framer's own modules
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [hdl/tick_divider.sv]
// divider that makes the 16x oversampling enable pulse
// assumes div_value is held steady; a value of n gives one tick per n+1 clocks
`timescale 1ns/1ps
module tick_divider #(
  parameter int WIDTH = framer_pkg::DIV_WIDTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] div_value,
  output logic tick
);
  logic [WIDTH-1:0] count_reg;

  // count up and pulse on wrap
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg >= div_value) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// [hdl/word_fifo.sv]
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock; reads and writes may happen in the same cycle
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = framer_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty flags
  assign in_s.ready = (count_reg != DEPTH[AW:0]);
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_s.data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// [test/serial_partner.sv]
// far end of the serial line: sends characters on rx_line and decodes tx_line
// assumes one tick per core clock, so one bit time is 16 core clocks
`timescale 1ns/1ps
module serial_partner (
  input wire logic core_clk,
  input wire logic tx_line,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  output logic rx_line
);
  logic [9:0] got_q[$]; // data, parity and stop sample of each character
  int low_q[$]; // low clocks from the start edge
  int gap_q[$]; // high clocks before each start edge
  int hi_run;
  int j;
  int low;
  int nb;
  logic [9:0] sh;

  initial begin
    rx_line = 1'b1;
    hi_run = 0;
  end

  // start, then n bits, then stop_val for stop_clk clocks, all as the caller chooses
  task automatic send(input logic [9:0] bits, input int n, input logic stop_val,
                      input int stop_clk);
    @(negedge core_clk);
    rx_line = 1'b0;
    repeat (16) @(negedge core_clk);
    for (int k = 0; k < n; k++) begin
      rx_line = bits[k];
      repeat (16) @(negedge core_clk);
    end
    rx_line = stop_val;
    repeat (stop_clk) @(negedge core_clk);
    rx_line = 1'b1;
  endtask

  // centre sampling counted from the start edge
  initial begin
    forever begin
      @(negedge core_clk); // clear of the edge that launches tx_line
      if (tx_line !== 1'b0) begin
        hi_run++;
      end else begin
        gap_q.push_back(hi_run);
        j = 0;
        low = 0;
        sh = 10'h000;
        nb = int'(nbits) + int'(par_en);
        while (j < 8 + 16 * (1 + nb)) begin
          @(negedge core_clk);
          j++;
          if (low == 0 && tx_line === 1'b1) low = j;
          if (j > 8 && j % 16 == 8) sh[j / 16 - 1] = tx_line;
        end
        got_q.push_back(sh);
        low_q.push_back(low);
        hi_run = 9; // stop has been high since its start up to its centre
      end
    end
  end
endmodule

// [test/test_async_start_stop_serial_framer.sv]
// self-checking bench for the start-stop serial framer
// assumes tick_div of zero, so one 16x tick per core clock, until tx_slow_tick sets it to one
`timescale 1ns/1ps
`define chk(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_async_start_stop_serial_framer;
  logic core_clk, reset_n, parity_en, parity_even, two_stop, tx_valid, tx_ready;
  logic tx_line, rx_line, rx_avail, rx_unload, parity_err, frame_err, overrun_err;
  logic [1:0] word_len;
  logic [7:0] tx_data, rx_data;
  logic [15:0] tick_div;
  int n_fail, n_checks;

  async_start_stop_serial_framer u_async_start_stop_serial_framer (
    .core_clk(core_clk), .reset_n(reset_n), .tick_div(tick_div), .word_len(word_len),
    .parity_en(parity_en), .parity_even(parity_even), .two_stop(two_stop),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
    .rx_line(rx_line), .rx_data(rx_data), .rx_avail(rx_avail), .rx_unload(rx_unload),
    .parity_err(parity_err), .frame_err(frame_err), .overrun_err(overrun_err));

  serial_partner u_serial_partner (.core_clk(core_clk), .tx_line(tx_line),
    .nbits({2'b00, word_len} + 4'h5), .par_en(parity_en), .rx_line(rx_line));

  // clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // config changes only once the line has settled idle
  task automatic set_cfg(input logic [1:0] wl, input logic pe, pev, ts);
    repeat (48) @(negedge core_clk);
    word_len = wl;
    parity_en = pe;
    parity_even = pev;
    two_stop = ts;
    u_serial_partner.got_q.delete();
    u_serial_partner.low_q.delete();
    u_serial_partner.gap_q.delete();
  endtask

  task automatic wait_tx(input int n);
    for (int w = 0; w < 9000 && u_serial_partner.got_q.size() < n; w++) @(posedge core_clk);
    `chk(u_serial_partner.got_q.size() == n, 1'b1)
  endtask

  task automatic unload();
    @(negedge core_clk);
    rx_unload = 1'b1;
    @(negedge core_clk);
    rx_unload = 1'b0;
    `chk(rx_avail, 1'b0)
  endtask

  task automatic tx_lengths();
    logic [7:0] m;
    logic [9:0] g;
    for (int wl = 0; wl < 4; wl++) begin
      set_cfg(wl[1:0], 1'b1, wl[0], 1'b1);
      m = 8'hff >> (3 - wl);
      tx_data = 8'hb5;
      tx_valid = 1'b1;
      repeat (2) @(negedge core_clk);
      tx_valid = 1'b0;
      wait_tx(2);
      g = u_serial_partner.got_q[0];
      `chk(g[7:0] & m, 8'hb5 & m)
      `chk(g[5 + wl], ^(8'hb5 & m) ^ ~wl[0])
      `chk(g[6 + wl], 1'b1)
      `chk(u_serial_partner.low_q[0], 16)
      `chk(u_serial_partner.gap_q[1], (wl == 0) ? 25 : 33)
    end
    $display("test tx_lengths done");
  endtask

  task automatic tx_fifo_fill();
    int acc;
    int hi;
    set_cfg(2'h3, 1'b0, 1'b0, 1'b1);
    acc = 0;
    @(negedge core_clk);
    while (acc < 24 && tx_ready === 1'b1) begin
      tx_valid = 1'b1;
      tx_data = 8'h01 + 8'(2 * acc);
      acc++;
      @(negedge core_clk);
    end
    tx_valid = 1'b0;
    `chk(acc >= 16 && acc <= 17, 1'b1)
    wait_tx(acc);
    for (int k = 0; k < acc && k < u_serial_partner.got_q.size(); k++) begin
      `chk(u_serial_partner.got_q[k][7:0], 8'h01 + 8'(2 * k))
      `chk(u_serial_partner.got_q[k][8], 1'b1)
      if (k > 0) begin
        hi = u_serial_partner.gap_q[k];
        `chk(hi >= 32 && hi <= 34, 1'b1)
      end
    end
    hi = 0;
    repeat (200) begin
      @(negedge core_clk);
      if (tx_line === 1'b1) hi++;
    end
    `chk(hi, 200)
    $display("test tx_fifo_fill done");
  endtask

  task automatic rx_lengths();
    logic [7:0] d;
    for (int wl = 0; wl < 4; wl++) begin
      set_cfg(wl[1:0], 1'b1, 1'b0, 1'b0);
      d = 8'hca & (8'hff >> (3 - wl));
      u_serial_partner.send({2'b00, d} | ({9'h000, ~^d} << (5 + wl)), 6 + wl, 1'b1, 15);
      for (int w = 0; w < 64 && rx_avail !== 1'b1; w++) @(negedge core_clk);
      `chk(rx_avail, 1'b1)
      `chk(rx_data, d)
      `chk({parity_err, frame_err, overrun_err}, 3'h0)
      unload();
    end
    $display("test rx_lengths done");
  endtask

  task automatic rx_short();
    set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
    // false start: back at mark before the start centre
    @(negedge core_clk);
    u_serial_partner.rx_line = 1'b0;
    repeat (4) @(negedge core_clk);
    u_serial_partner.rx_line = 1'b1;
    repeat (160) @(negedge core_clk);
    `chk(rx_avail, 1'b0)
    u_serial_partner.send(10'h05a, 8, 1'b1, 8);
    u_serial_partner.send(10'h03c, 8, 1'b1, 15);
    @(negedge core_clk);
    `chk(rx_data, 8'h3c)
    `chk(overrun_err, 1'b1)
    `chk(frame_err, 1'b0)
    unload();
    $display("test rx_short done");
  endtask

  task automatic rx_errors();
    set_cfg(2'h3, 1'b1, 1'b1, 1'b0);
    u_serial_partner.send(10'h103, 9, 1'b1, 15);
    `chk(parity_err, 1'b1)
    `chk(frame_err, 1'b0)
    `chk(overrun_err, 1'b0)
    unload();
    set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
    u_serial_partner.send(10'h081, 8, 1'b0, 15);
    `chk(frame_err, 1'b1)
    `chk(parity_err, 1'b0)
    `chk(rx_data, 8'h81)
    unload();
    $display("test rx_errors done");
  endtask

  // reset in mid-character, then a clean character afterwards
  task automatic mid_reset();
    set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
    u_serial_partner.send(10'h081, 8, 1'b0, 15);
    `chk({rx_avail, frame_err}, 2'h3)
    tx_data = 8'h5a;
    tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b0;
    repeat (10) @(negedge core_clk);
    `chk({tx_line, tx_ready, rx_avail, frame_err}, 4'hc)
    `chk(rx_data, 8'h00)
    reset_n = 1'b1;
    repeat (150) @(negedge core_clk);
    set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0;
    wait_tx(1);
    `chk(u_serial_partner.got_q[0][7:0], 8'h3c)
    $display("test mid_reset done");
  endtask

  // one 16x tick every two clocks doubles the start element
  task automatic tx_slow_tick();
    set_cfg(2'h3, 1'b0, 1'b0, 1'b0);
    tick_div = 16'h0001;
    tx_data = 8'hb5;
    tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0;
    for (int w = 0; w < 400 && u_serial_partner.low_q.size() == 0; w++) @(negedge core_clk);
    `chk(u_serial_partner.low_q.size() > 0, 1'b1)
    `chk(u_serial_partner.low_q[0], 32)
    $display("test tx_slow_tick done");
  endtask

  // watchdog sized well above the expected run of about 7400 clocks
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    reset_n = 1'b0;
    word_len = 2'h3;
    parity_en = 1'b0;
    parity_even = 1'b0;
    two_stop = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_unload = 1'b0;
    tick_div = 16'h0000;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    `chk({tx_line, tx_ready, rx_avail}, 3'h6)
    tx_lengths();
    tx_fifo_fill();
    rx_lengths();
    rx_short();
    rx_errors();
    mid_reset();
    tx_slow_tick();
    tally_and_finish();
  end
endmodule
